// file: verilog/bpf_pkg.sv
// Constants and carrier types for the branch prediction front end.
// Assumes one core clock; byte-granular linear addresses.
package bpf_pkg;
	// ----------------------------------------
	// Widths and sizes
	// ----------------------------------------
	localparam int ADDR_W = 32;
	localparam int TBL_ENTRIES = 16;
	localparam int RAS_DEPTH = 16;
	localparam int PIPE_DEPTH = 20;
	localparam int TRACE_CAP = 12288;
	localparam int UOPS_PER_CYC = 3;
	localparam int OCC_W = 14;
	// ----------------------------------------
	// Counter encodings
	// ----------------------------------------
	localparam logic [1:0] CTR_ALLOC_TAKEN = 2'h2;
	localparam logic [1:0] CTR_ALLOC_NOT = 2'h1;
	localparam logic [1:0] CTR_MAX = 2'h3;
	localparam logic [1:0] CTR_MIN = 2'h0;
	// ----------------------------------------
	// Transfer kinds
	// ----------------------------------------
	typedef enum logic [3:0] {
		BPF_K_NONE,
		BPF_K_COND,
		BPF_K_CALL,
		BPF_K_RET,
		BPF_K_INDIR,
		BPF_K_JMP,
		BPF_K_FAR_CALL,
		BPF_K_FAR_RET,
		BPF_K_SOFT_INT
	} bpf_kind_t;
	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		bpf_kind_t kind;
		logic [ADDR_W-1:0] addr;
		logic [ADDR_W-1:0] disp;
		logic [ADDR_W-1:0] next_addr;
		logic dyn_ok;
	} bpf_dec_t;
	typedef struct packed {
		bpf_kind_t kind;
		logic [ADDR_W-1:0] addr;
		logic taken;
		logic [ADDR_W-1:0] target;
		logic mispred;
	} bpf_ret_t;
	typedef struct packed {
		logic vld;
		logic taken;
		logic [ADDR_W-1:0] target;
	} bpf_pred_t;
endpackage

// file: verilog/bpf_front_end.sv
// Branch prediction front end: table, static fallback, return stack, flush, trace delivery.
// Assumes fetch, decode and retirement logic on the same core clock.
`timescale 1ns/1ps
module bpf_front_end import bpf_pkg::*; #(
	parameter int ENTRIES = TBL_ENTRIES,
	parameter int STACK_DEPTH = RAS_DEPTH,
	parameter int FLUSH_CYCLES = PIPE_DEPTH,
	parameter int TC_CAP = TRACE_CAP
) (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_nrst,
	// Fetch lookup
	input wire logic i_fetch_vld,
	input wire logic [ADDR_W-1:0] i_fetch_addr,
	output bpf_pred_t o_dyn_pred,
	// Decode
	input wire logic i_dec_vld,
	input wire bpf_dec_t i_dec,
	output bpf_pred_t o_dec_pred,
	output logic o_dec_far,
	output logic o_trace_join,
	// Retirement
	input wire logic i_ret_vld,
	input wire bpf_ret_t i_ret,
	output logic o_flush,
	output logic [ADDR_W-1:0] o_refetch_addr,
	output logic o_fe_stall,
	// Trace store
	input wire logic i_tc_hit,
	input wire logic [1:0] i_tc_uops,
	input wire logic i_tc_fill_vld,
	input wire logic [3:0] i_tc_fill_uops,
	input wire logic i_tc_evict_vld,
	input wire logic [3:0] i_tc_evict_uops,
	output logic [1:0] o_uop_cnt,
	output logic o_ucode_sel,
	output logic o_tc_full
);
	localparam int IDX_W = $clog2(ENTRIES);
	localparam int SP_W = $clog2(STACK_DEPTH);
	localparam int FC_W = $clog2(FLUSH_CYCLES + 1);
	localparam logic [OCC_W-1:0] CAP = OCC_W'(TC_CAP);
	localparam logic [1:0] UOP_MAX = 2'(UOPS_PER_CYC);
	// ----------------------------------------
	// Branch history and target table
	// ----------------------------------------
	logic [ENTRIES-1:0] vld_q;
	logic [ADDR_W-1:0] tag_q [ENTRIES], tgt_q [ENTRIES];
	logic [1:0] ctr_q [ENTRIES];
	logic [IDX_W-1:0] ret_idx;
	logic upd_en;
	assign ret_idx = i_ret.addr[IDX_W-1:0];
	// Far transfers and returns never train the table
	assign upd_en = i_ret_vld && (i_ret.kind == BPF_K_COND || i_ret.kind == BPF_K_CALL
		|| i_ret.kind == BPF_K_JMP || i_ret.kind == BPF_K_INDIR);
	generate
		for (genvar g = 0; g < ENTRIES; g++) begin : g_ent
			logic hit_d, vld_d;
			logic [ADDR_W-1:0] tag_d, tgt_d;
			logic [1:0] ctr_d;
			always_comb begin
				hit_d = vld_q[g] && tag_q[g] == i_ret.addr;
				vld_d = vld_q[g];
				tag_d = tag_q[g];
				tgt_d = tgt_q[g];
				ctr_d = ctr_q[g];
				if (upd_en && ret_idx == IDX_W'(g)) begin
					vld_d = 1'b1;
					tag_d = i_ret.addr;
					tgt_d = (i_ret.taken || !hit_d) ? i_ret.target : tgt_q[g];
					if (!hit_d) begin
						ctr_d = i_ret.taken ? CTR_ALLOC_TAKEN : CTR_ALLOC_NOT;
					end else if (i_ret.taken && ctr_q[g] != CTR_MAX) begin
						ctr_d = ctr_q[g] + 2'h1;
					end else if (!i_ret.taken && ctr_q[g] != CTR_MIN) begin
						ctr_d = ctr_q[g] - 2'h1;
					end
				end
			end
			always_ff @(posedge i_core_clk) begin
				if (!i_nrst) begin
					vld_q[g] <= 1'b0;
					tag_q[g] <= '0;
					tgt_q[g] <= '0;
					ctr_q[g] <= CTR_MIN;
				end else begin
					vld_q[g] <= vld_d;
					tag_q[g] <= tag_d;
					tgt_q[g] <= tgt_d;
					ctr_q[g] <= ctr_d;
				end
			end
		end
	endgenerate
	// ----------------------------------------
	// Fetch-time lookup
	// ----------------------------------------
	bpf_pred_t dyn_d, dyn_q;
	logic [IDX_W-1:0] f_idx;
	assign f_idx = i_fetch_addr[IDX_W-1:0];
	always_comb begin
		dyn_d.vld = i_fetch_vld && vld_q[f_idx] && tag_q[f_idx] == i_fetch_addr;
		dyn_d.taken = dyn_d.vld && ctr_q[f_idx][1];
		dyn_d.target = tgt_q[f_idx];
	end
	always_ff @(posedge i_core_clk) begin
		if (!i_nrst) begin
			dyn_q <= '0;
		end else begin
			dyn_q <= dyn_d;
		end
	end
	assign o_dyn_pred = dyn_q;
	// ----------------------------------------
	// Decode-time prediction and return stack
	// ----------------------------------------
	logic [ADDR_W-1:0] ras_q [STACK_DEPTH], ras_d [STACK_DEPTH];
	logic [SP_W-1:0] sp_d, sp_q, top;
	logic [SP_W:0] depth_d, depth_q;
	bpf_pred_t dec_d, dec_q;
	logic far_d, far_q, join_d, join_q;
	logic [ADDR_W-1:0] disp_tgt;
	assign disp_tgt = i_dec.addr + i_dec.disp;
	assign top = sp_q - SP_W'(1);
	always_comb begin
		ras_d = ras_q;
		sp_d = sp_q;
		depth_d = depth_q;
		dec_d = '0;
		far_d = 1'b0;
		if (i_dec_vld) begin
			case (i_dec.kind)
				BPF_K_COND: begin
					dec_d.vld = !i_dec.dyn_ok;
					dec_d.taken = i_dec.disp[ADDR_W-1];
					dec_d.target = i_dec.disp[ADDR_W-1] ? disp_tgt : i_dec.next_addr;
				end
				BPF_K_JMP, BPF_K_CALL: begin
					dec_d.vld = !i_dec.dyn_ok;
					dec_d.taken = 1'b1;
					dec_d.target = disp_tgt;
					if (i_dec.kind == BPF_K_CALL) begin
						ras_d[sp_q] = i_dec.next_addr;
						sp_d = sp_q + SP_W'(1);
						if (depth_q != (SP_W+1)'(STACK_DEPTH)) begin
							depth_d = depth_q + (SP_W+1)'(1);
						end
					end
				end
				BPF_K_RET: begin
					dec_d.vld = 1'b1;
					dec_d.taken = 1'b1;
					dec_d.target = ras_q[top];
					if (depth_q != '0) begin
						sp_d = top;
						depth_d = depth_q - (SP_W+1)'(1);
					end
				end
				BPF_K_INDIR: dec_d.vld = 1'b0;
				BPF_K_FAR_CALL, BPF_K_FAR_RET, BPF_K_SOFT_INT: far_d = 1'b1;
				default: dec_d = '0;
			endcase
		end
		join_d = dec_d.vld && dec_d.taken;
	end
	always_ff @(posedge i_core_clk) begin
		if (!i_nrst) begin
			ras_q <= '{default: '0};
			sp_q <= '0;
			depth_q <= '0;
			dec_q <= '0;
			far_q <= 1'b0;
			join_q <= 1'b0;
		end else begin
			ras_q <= ras_d;
			sp_q <= sp_d;
			depth_q <= depth_d;
			dec_q <= dec_d;
			far_q <= far_d;
			join_q <= join_d;
		end
	end
	assign o_dec_pred = dec_q;
	assign o_dec_far = far_q;
	assign o_trace_join = join_q;
	// ----------------------------------------
	// Mispredict flush
	// ----------------------------------------
	logic [FC_W-1:0] fc_d, fc_q;
	logic flush_d, flush_q, stall_d, stall_q;
	logic [ADDR_W-1:0] rf_d, rf_q;
	always_comb begin
		flush_d = i_ret_vld && i_ret.mispred;
		rf_d = rf_q;
		fc_d = (fc_q != '0) ? fc_q - FC_W'(1) : fc_q;
		if (flush_d) begin
			rf_d = i_ret.taken ? i_ret.target : i_ret.addr;
			fc_d = FC_W'(FLUSH_CYCLES);
		end
		stall_d = fc_d != '0;
	end
	always_ff @(posedge i_core_clk) begin
		if (!i_nrst) begin
			fc_q <= '0;
			flush_q <= 1'b0;
			stall_q <= 1'b0;
			rf_q <= '0;
		end else begin
			fc_q <= fc_d;
			flush_q <= flush_d;
			stall_q <= stall_d;
			rf_q <= rf_d;
		end
	end
	assign o_flush = flush_q;
	assign o_refetch_addr = rf_q;
	assign o_fe_stall = stall_q;
	// ----------------------------------------
	// Trace store delivery and occupancy
	// ----------------------------------------
	logic [OCC_W-1:0] occ_d, occ_q;
	logic [1:0] cnt_d, cnt_q;
	logic uc_d, uc_q, full_d, full_q;
	always_comb begin
		occ_d = occ_q;
		if (i_tc_evict_vld) begin
			occ_d = (occ_d > OCC_W'(i_tc_evict_uops)) ? occ_d - OCC_W'(i_tc_evict_uops) : '0;
		end
		if (i_tc_fill_vld && occ_d + OCC_W'(i_tc_fill_uops) <= CAP) begin
			occ_d = occ_d + OCC_W'(i_tc_fill_uops);
		end
		full_d = occ_d + OCC_W'(4'hF) > CAP;
		uc_d = !i_tc_hit;
		cnt_d = (i_tc_hit && fc_q == '0) ? ((i_tc_uops > UOP_MAX) ? UOP_MAX : i_tc_uops) : 2'h0;
	end
	always_ff @(posedge i_core_clk) begin
		if (!i_nrst) begin
			occ_q <= '0;
			cnt_q <= 2'h0;
			uc_q <= 1'b0;
			full_q <= 1'b0;
		end else begin
			occ_q <= occ_d;
			cnt_q <= cnt_d;
			uc_q <= uc_d;
			full_q <= full_d;
		end
	end
	assign o_uop_cnt = cnt_q;
	assign o_ucode_sel = uc_q;
	assign o_tc_full = full_q;
	// ----------------------------------------
	// Checks
	// ----------------------------------------
	chk_far_no_pred: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
		o_dec_far |-> !o_dec_pred.vld) else $error("far transfer was predicted");
	chk_ret_taken: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
		i_dec_vld && i_dec.kind == BPF_K_RET |=> o_dec_pred.vld && o_dec_pred.taken)
		else $error("return not predicted taken");
	chk_back_taken: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
		i_dec_vld && i_dec.kind == BPF_K_COND && !i_dec.dyn_ok && i_dec.disp[ADDR_W-1]
		|=> o_dec_pred.vld && o_dec_pred.taken) else $error("backward branch not taken");
	chk_fwd_not: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
		i_dec_vld && i_dec.kind == BPF_K_COND && !i_dec.disp[ADDR_W-1]
		|=> !o_dec_pred.taken) else $error("forward branch predicted taken");
	chk_flush_stall: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
		$rose(o_flush) |-> o_fe_stall && fc_q == FC_W'(FLUSH_CYCLES))
		else $error("flush without full stall");
	chk_uop_limit: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
		o_uop_cnt <= UOP_MAX && occ_q <= CAP) else $error("trace store limit broken");
	chk_tbl_retire: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
		!upd_en |=> $stable(vld_q)) else $error("table changed without retirement");
	chk_zero_bubble: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
		i_ret_vld && !i_ret.mispred && !o_fe_stall |=> !o_flush && !o_fe_stall)
		else $error("correct prediction caused a stall");
	chk_ucode_sel: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
		!i_tc_hit |=> o_ucode_sel && o_uop_cnt == 2'h0) else $error("microcode not selected");
	chk_call_push: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
		i_dec_vld && i_dec.kind == BPF_K_CALL |=> ras_q[$past(sp_q)] == $past(i_dec.next_addr))
		else $error("call did not push return address");
endmodule

// file: bench/bpf_retire_model.sv
// Retirement side model: issues one resolved branch outcome per request.
// Assumes the bench raises i_go for one cycle per retire, at the rising edge.
`timescale 1ns/1ps
module bpf_retire_model import bpf_pkg::*; (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_nrst,
	// Bench request
	input wire logic i_go,
	input wire bpf_ret_t i_rec,
	// Toward the front end
	output logic o_ret_vld,
	output bpf_ret_t o_ret
);
	// ----------------------------------------
	// Retire issue
	// ----------------------------------------
	// Outcome leaves only at retirement; idle bus shows inverted junk
	always_ff @(posedge i_core_clk) begin
		if (!i_nrst) begin
			o_ret_vld <= 1'b0;
			o_ret <= '0;
		end else begin
			o_ret_vld <= i_go;
			o_ret <= i_go ? i_rec : bpf_ret_t'(~o_ret);
		end
	end
endmodule

// file: bench/bpf_front_end_test.sv
// Self-checking bench for the branch prediction front end.
// Assumes the retirement model beside it; short flush and trace capacity.
`timescale 1ns/1ps
module bpf_front_end_test import bpf_pkg::*;;
	localparam int FC = 4;
	localparam int CAP = 64;
	logic clk = 0, nrst = 0, fv = 0, dv = 0, go = 0, tch = 0, tcf = 0, tce = 0;
	logic [ADDR_W-1:0] fa = '0;
	bpf_dec_t dec = '0;
	bpf_ret_t rec = '0;
	logic [1:0] tcu = '0;
	logic [3:0] tfu = '0, teu = '0;
	logic ret_vld, far, tjoin, flush, stall, ucode, full;
	bpf_ret_t ret;
	bpf_pred_t dyn, dp;
	logic [ADDR_W-1:0] refetch;
	logic [1:0] ucnt;
	int miscompares = 0;
	int n_checks = 0;
	// ----------------------------------------
	// Instances
	// ----------------------------------------
	bpf_retire_model i_bpf_retire_model(.i_core_clk(clk), .i_nrst(nrst), .i_go(go),
		.i_rec(rec), .o_ret_vld(ret_vld), .o_ret(ret));
	bpf_front_end #(.FLUSH_CYCLES(FC), .TC_CAP(CAP)) i_bpf_front_end(.i_core_clk(clk),
		.i_nrst(nrst), .i_fetch_vld(fv), .i_fetch_addr(fa), .o_dyn_pred(dyn),
		.i_dec_vld(dv), .i_dec(dec), .o_dec_pred(dp), .o_dec_far(far),
		.o_trace_join(tjoin), .i_ret_vld(ret_vld), .i_ret(ret), .o_flush(flush),
		.o_refetch_addr(refetch), .o_fe_stall(stall), .i_tc_hit(tch), .i_tc_uops(tcu),
		.i_tc_fill_vld(tcf), .i_tc_fill_uops(tfu), .i_tc_evict_vld(tce),
		.i_tc_evict_uops(teu), .o_uop_cnt(ucnt), .o_ucode_sel(ucode), .o_tc_full(full));
	initial begin
		forever #5 clk = ~clk;
	end
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		if (miscompares == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic dec_op(input bpf_kind_t k, input logic [31:0] a, d, n, input logic ok);
		@(posedge clk);
		dv <= 1'b1;
		dec <= '{k, a, d, n, ok};
		@(posedge clk);
		dv <= 1'b0;
		#1;
	endtask
	task automatic fetch(input logic [31:0] a);
		@(posedge clk);
		fv <= 1'b1;
		fa <= a;
		@(posedge clk);
		fv <= 1'b0;
		#1;
	endtask
	task automatic ret_op(input bpf_ret_t r);
		@(posedge clk);
		go <= 1'b1;
		rec <= r;
		@(posedge clk);
		go <= 1'b0;
		@(posedge clk);
		#1;
	endtask
	task automatic tc_op(input logic f, e);
		@(posedge clk);
		tcf <= f;
		tce <= e;
		tfu <= 4'hF;
		teu <= 4'hF;
		@(posedge clk);
		tcf <= 1'b0;
		tce <= 1'b0;
		#1;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_static();
		dec_op(BPF_K_COND, 32'h1000, 32'hFFFFFFF0, 32'h1004, 1'b0);
		chk(dp, {2'h3, 32'h00000FF0});
		chk(tjoin, 1'b1);
		dec_op(BPF_K_COND, 32'h2000, 32'h40, 32'h2004, 1'b0);
		chk({dp.vld, dp.taken, tjoin}, 3'h4);
	endtask
	task automatic t_far();
		bpf_kind_t ks[3] = '{BPF_K_FAR_CALL, BPF_K_FAR_RET, BPF_K_SOFT_INT};
		for (int i = 0; i < 3; i++) begin
			dec_op(ks[i], 32'h7000, 32'h10, 32'h7004, 1'b0);
			chk({far, dp.vld}, 2'h2);
		end
	endtask
	task automatic t_stack();
		logic [31:0] e;
		for (int i = 0; i <= 16; i++) begin
			dec_op(BPF_K_CALL, 32'h100, 32'h400, 32'h3000 + i, 1'b0);
		end
		for (int i = 16; i >= 1; i--) begin
			e = 32'h3000 + i;
			dec_op(BPF_K_RET, 32'h5000, 32'h0, 32'h5004, 1'b0);
			chk(dp, {2'h3, e});
		end
	endtask
	task automatic t_table();
		int cnt;
		fetch(32'h104);
		chk(dyn.vld, 1'b0);
		ret_op('{BPF_K_COND, 32'h104, 1'b1, 32'h9000, 1'b1});
		chk({flush, stall, ucnt, refetch}, {4'hF, 32'h9000});
		cnt = 1;
		for (int i = 0; i < 30 && stall === 1'b1; i++) begin
			@(posedge clk);
			#1;
			if (stall === 1'b1) begin
				cnt++;
			end
		end
		chk(cnt, FC);
		fetch(32'h104);
		chk(dyn, {2'h3, 32'h9000});
		fetch(32'h114);
		chk(dyn.vld, 1'b0);
		dec_op(BPF_K_COND, 32'h104, 32'h40, 32'h108, 1'b1);
		chk(dp.vld, 1'b0);
		ret_op('{BPF_K_COND, 32'h104, 1'b1, 32'h9000, 1'b0});
		chk({flush, stall, ucnt}, 4'h3);
		@(posedge clk);
		fv <= 1'b1;
		fa <= 32'h114;
		@(posedge clk);
		fa <= 32'h104;
		#1;
		chk(dyn.vld, 1'b0);
		@(posedge clk);
		fv <= 1'b0;
		#1;
		chk(dyn, {2'h3, 32'h9000});
	endtask
	task automatic t_trace();
		@(posedge clk);
		tch <= 1'b0;
		@(posedge clk);
		tch <= 1'b1;
		#1;
		chk({ucode, ucnt}, 3'h4);
		@(posedge clk);
		#1;
		chk({ucode, ucnt}, 3'h3);
		repeat (3) tc_op(1'b1, 1'b0);
		chk(full, 1'b0);
		tc_op(1'b1, 1'b0);
		chk(full, 1'b1);
		tc_op(1'b1, 1'b0);
		tc_op(1'b0, 1'b1);
		chk(full, 1'b0);
	endtask
	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial begin
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		tch <= 1'b1;
		tcu <= 2'h3;
		t_static();
		t_far();
		t_stack();
		t_table();
		t_trace();
		final_report();
	end
	initial begin
		#20000;
		miscompares++;
		final_report();
	end
endmodule
